// >>> hdl/csync_pkg.sv
// Package with constants for the cyclic synchronous setpoint follower
package csync_pkg;
  localparam int          POS_W        = 32;              // Position / velocity word width
  localparam int          TRQ_W        = 16;              // Torque word width
  localparam int          STAT_W       = 16;              // Status word width
  localparam logic [7:0]  MODE_CSP     = 8'h08;           // Cyclic synchronous position
  localparam logic [7:0]  MODE_CSV     = 8'h09;           // Cyclic synchronous velocity
  localparam logic signed [7:0] TIME_INDEX_MS = -8'sd3;   // Only supported time index
  localparam int          STAT_SYNC    = 8;               // Status bit: in sync
  localparam int          STAT_LIMIT   = 11;              // Status bit: limit exceeded
  localparam int          STAT_FOLLOW  = 12;              // Status bit: target followed
  localparam int          STAT_FERR    = 13;              // Status bit: following error
  localparam int          CLK_HZ       = 20000000;        // System clock rate
  localparam int          BASE_US      = 1000;            // Time base, microseconds
  localparam int          MS_CYCLES    = CLK_HZ / 1000000 * BASE_US; // Cycles per ms
  localparam int          FIFO_DEPTH   = 4;               // Setpoint FIFO depth
  localparam logic [1:0]  QS_HOLD      = 2'h0;            // Quick stop: hold at stop
  localparam logic [1:0]  QS_DISABLE   = 2'h1;            // Quick stop: drop follow after stop
endpackage

// >>> hdl/setpoint_fifo.sv
// Small valid/ready FIFO carrying setpoints
`timescale 1ns/1ps
module setpoint_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // Storage array
  logic [AW-1:0]    wr_ptr;        // Write pointer
  logic [AW-1:0]    rd_ptr;        // Read pointer
  logic [AW:0]      count;         // Fill level
  wire              do_wr = in_valid && in_ready;
  wire              do_rd = out_valid && out_ready;
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  // Storage write, no reset needed
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // Pointers and level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// >>> hdl/cyclic_sync_setpoint_follower.sv
// Setpoint follower for cyclic synchronous position and velocity modes
`timescale 1ns/1ps
// Functional notes
// - Mode code 8 selects cyclic position
// - Mode code 9 selects cyclic velocity
// - No ramps; setpoint passed straight through
// - Absolute target; repeated writes are idempotent
// - Control bit 4 not needed for acceptance
// - Status bit 8 shows fieldbus sync
// - Status bit 12 shows target followed
// - Velocity mode: bit 12 used, 10/13 reserved
// - Bit 13 on window violation past timeout
// - Following error timeout counted in ms
// - Bit 11 when demand outside soft limits
// - Commanded position clamped to soft limits
// - Range limit wraps overrun and underrun
// - Cycle period is period value times base
// - Only index -3, one millisecond base
// - Sync starts on the first SYNC pulse while Operational in a cyclic mode
// - Quick stop brakes with set deceleration
// - Torque demand is the torque offset alone; there is no torque setpoint
// - Position and velocity offsets added
module cyclic_sync_setpoint_follower
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic [7:0]              op_mode,
  input  wire logic                    operational,
  input  wire logic                    sync_pulse,
  input  wire logic                    quick_stop,
  input  wire logic [1:0]              qs_option,
  input  wire logic [csync_pkg::POS_W-1:0] qs_decel,
  input  wire logic [7:0]              interp_period,
  input  wire logic signed [7:0]       interp_index,
  input  wire logic signed [csync_pkg::POS_W-1:0] sp_data,
  input  wire logic                    sp_valid,
  output logic                         sp_ready,
  input  wire logic signed [csync_pkg::POS_W-1:0] actual_pos,
  input  wire logic signed [csync_pkg::POS_W-1:0] soft_min,
  input  wire logic signed [csync_pkg::POS_W-1:0] soft_max,
  input  wire logic                    range_wrap,
  input  wire logic signed [csync_pkg::POS_W-1:0] range_min,
  input  wire logic signed [csync_pkg::POS_W-1:0] range_max,
  input  wire logic [csync_pkg::POS_W-1:0] ferr_window,
  input  wire logic [15:0]             ferr_timeout_ms,
  input  wire logic signed [csync_pkg::POS_W-1:0] pos_offset,
  input  wire logic signed [csync_pkg::POS_W-1:0] vel_offset,
  input  wire logic signed [csync_pkg::TRQ_W-1:0] trq_offset,
  output logic signed [csync_pkg::POS_W-1:0] pos_demand,
  output logic signed [csync_pkg::POS_W-1:0] vel_demand,
  output logic signed [csync_pkg::TRQ_W-1:0] trq_demand,
  output logic [csync_pkg::STAT_W-1:0] status_word,
  output logic                         cycle_tick
);
  import csync_pkg::*;

  // Follower states: idle, following, braking after quick stop, halted
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_QSTOP, ST_HALTED} run_e;

  run_e                     state;         // Follower state
  run_e                     next_state;    // Next follower state
  logic [14:0]              ms_cnt;        // Divider for the 1 ms tick
  logic [7:0]               per_cnt;       // Milliseconds into the cycle
  logic                     ms_tick;       // One-cycle pulse every ms
  logic                     in_sync;       // Locked to sync pulses
  logic                     have_sp;       // A setpoint has been received
  logic signed [POS_W-1:0]  latest_sp;     // Most recent setpoint
  logic signed [POS_W-1:0]  target;        // Setpoint held for this cycle
  logic [15:0]              ferr_ms;       // Ms spent outside window
  logic                     ferr;          // Following error flag
  logic                     lim_flag;      // Limit exceeded flag
  logic signed [POS_W-1:0]  fifo_data;     // FIFO output word
  logic                     fifo_valid;    // FIFO output valid

  // Mode decode
  wire mode_pos   = (op_mode == MODE_CSP);
  wire mode_vel   = (op_mode == MODE_CSV);
  wire mode_ok    = mode_pos || mode_vel;
  wire index_ok   = (interp_index == TIME_INDEX_MS);
  // Cycle boundary: on sync when locked, else on local period count
  wire local_end  = ms_tick && (per_cnt >= interp_period - 8'h01);
  wire boundary   = in_sync ? sync_pulse : local_end;
  wire following  = (state == ST_RUN) && mode_ok && have_sp && index_ok;

  // Setpoint buffer; the follower drains it every cycle so it never stalls
  setpoint_fifo #(.WIDTH(POS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (sp_data),
    .in_valid  (sp_valid),
    .in_ready  (sp_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (1'b1)
  );

  // Position path: offset, range handling, then soft limits
  // Wrap comes before the clamp so the clamp sees the final position
  wire signed [POS_W-1:0] pos_off  = target + pos_offset;
  wire signed [POS_W-1:0] span     = range_max - range_min + 32'sh1;
  wire signed [POS_W-1:0] pos_wrap =
    !range_wrap            ? pos_off :
    (pos_off > range_max)  ? pos_off - span :
    (pos_off < range_min)  ? pos_off + span : pos_off;
  wire over_lim  = pos_wrap > soft_max;
  wire under_lim = pos_wrap < soft_min;
  wire signed [POS_W-1:0] pos_clip =
    over_lim ? soft_max : (under_lim ? soft_min : pos_wrap);
  // Following error window check
  wire signed [POS_W-1:0] pos_err = actual_pos - pos_demand;
  wire [POS_W-1:0] err_mag = pos_err[POS_W-1] ? POS_W'(-pos_err) : POS_W'(pos_err);
  wire outside   = err_mag > ferr_window;
  // Quick-stop ramp toward zero speed
  // The last step lands on zero instead of overshooting into reverse
  wire signed [POS_W-1:0] vel_mag   = vel_demand[POS_W-1] ? -vel_demand : vel_demand;
  wire                    vel_small = $unsigned(vel_mag) <= qs_decel;
  wire signed [POS_W-1:0] vel_brake =
    vel_small ? '0 : (vel_demand[POS_W-1] ? vel_demand + $signed(qs_decel)
                                          : vel_demand - $signed(qs_decel));

  // Millisecond divider and cycle position
  // The tick is registered so every user sees one clean single-cycle pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b0;
      per_cnt <= '0;
    end else begin
      ms_tick <= (ms_cnt == 15'(MS_CYCLES - 1));
      ms_cnt  <= (ms_cnt == 15'(MS_CYCLES - 1)) ? '0 : ms_cnt + 15'h0001;
      if (boundary) begin
        per_cnt <= '0;
      end else if (ms_tick) begin
        per_cnt <= per_cnt + 8'h01;
      end
    end
  end

  // Sync lock follows the Operational state
  // Lock is lost at once when the node leaves Operational or a cyclic mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_sync <= 1'b0;
    end else if (!operational || !mode_ok) begin
      in_sync <= 1'b0;
    end else if (sync_pulse) begin
      in_sync <= 1'b1;
    end
  end

  // Latest setpoint, simply overwritten on each arrival while in a cyclic mode
  // An absolute target written twice leaves the same value behind
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latest_sp <= '0;
      have_sp   <= 1'b0;
    end else if (!mode_ok) begin
      have_sp   <= 1'b0;
    end else if (fifo_valid) begin
      latest_sp <= fifo_data;
      have_sp   <= 1'b1;
    end
  end

  // Held target taken only at the boundary
  // Words arriving mid-cycle wait here, so the control input never jumps
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      target <= '0;
    end else if (boundary && have_sp) begin
      target <= latest_sp;
    end
  end

  // Follower state machine
  always_comb begin
    next_state = state;
    unique case (state)
      // Start following once a cyclic mode is selected
      ST_IDLE: begin
        if (mode_ok && !quick_stop) begin
          next_state = ST_RUN;
        end
      end
      // Leave on mode change or quick stop request
      ST_RUN: begin
        if (!mode_ok) begin
          next_state = ST_IDLE;
        end else if (quick_stop) begin
          next_state = ST_QSTOP;
        end
      end
      // Brake until the velocity demand reaches zero
      ST_QSTOP: begin
        if (vel_small) begin
          next_state = ST_HALTED;
        end
      end
      // Release depends on the quick-stop option
      ST_HALTED: begin
        if (!quick_stop && qs_option == QS_HOLD) begin
          next_state = ST_IDLE;
        end else if (!quick_stop && !mode_ok) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Demand outputs: straight copy of the target, no ramp
  // Quick stop owns the velocity path until the halt is released
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pos_demand <= '0;
      vel_demand <= '0;
      trq_demand <= '0;
    end else begin
      trq_demand <= trq_offset;
      if (state == ST_QSTOP || state == ST_HALTED) begin
        vel_demand <= vel_brake;
      end else if (following && mode_pos) begin
        pos_demand <= pos_clip;
        vel_demand <= vel_offset;
      end else if (following && mode_vel) begin
        vel_demand <= target + vel_offset;
        pos_demand <= actual_pos;
      end
    end
  end

  // Following error timer in milliseconds
  // The timer restarts whenever the position returns inside the window
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ferr_ms <= '0;
      ferr    <= 1'b0;
    end else if (!(following && mode_pos) || !outside) begin
      ferr_ms <= '0;
      ferr    <= 1'b0;
    end else if (ms_tick) begin
      if (ferr_ms >= ferr_timeout_ms) begin
        ferr <= 1'b1;
      end else begin
        ferr_ms <= ferr_ms + 16'h0001;
      end
    end
  end

  // Limit flag from the unclipped demand
  // Registered so the flag lines up with the demand it describes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lim_flag <= 1'b0;
    end else begin
      lim_flag <= following && mode_pos && (over_lim || under_lim);
    end
  end

  // Status word assembly; bits 10 and 13 stay 0 in velocity mode
  always_comb begin
    status_word              = '0;
    status_word[STAT_SYNC]   = in_sync;
    status_word[STAT_FOLLOW] = following;
    status_word[STAT_LIMIT]  = lim_flag;
    status_word[STAT_FERR]   = ferr && mode_pos;
  end

  // Boundary marker for the controller side
  assign cycle_tick = boundary;

  // Checks
  chk_mode_follow: assert property (@(posedge clk_sys) disable iff (rst)
    status_word[STAT_FOLLOW] |-> (mode_pos || mode_vel))
    else $error("follow flag outside cyclic modes");
  chk_sync_needs_op: assert property (@(posedge clk_sys) disable iff (rst)
    !operational |=> !status_word[STAT_SYNC])
    else $error("sync flag without operational state");
  chk_sync_bit: assert property (@(posedge clk_sys) disable iff (rst)
    (operational && mode_ok && sync_pulse) |=> status_word[STAT_SYNC])
    else $error("sync flag not raised");
  chk_sync_mode_drop: assert property (@(posedge clk_sys) disable iff (rst)
    !mode_ok |=> !status_word[STAT_SYNC])
    else $error("sync flag outside cyclic modes");
  chk_target_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !boundary |=> $stable(target))
    else $error("target changed between boundaries");
  chk_vel_reserved: assert property (@(posedge clk_sys) disable iff (rst)
    mode_vel |-> !status_word[STAT_FERR] && !status_word[10])
    else $error("reserved bit set in velocity mode");
  chk_index_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !index_ok |-> !status_word[STAT_FOLLOW])
    else $error("follow flag with unsupported time index");
  chk_pos_direct: assert property (@(posedge clk_sys) disable iff (rst)
    (following && mode_pos && !range_wrap && !over_lim && !under_lim)
      |=> pos_demand == $past(target) + $past(pos_offset))
    else $error("position demand not the offset target");
  chk_vel_direct: assert property (@(posedge clk_sys) disable iff (rst)
    (following && mode_vel) |=> vel_demand == $past(target) + $past(vel_offset))
    else $error("velocity demand not the offset target");
  chk_pos_clamp: assert property (@(posedge clk_sys) disable iff (rst)
    (following && mode_pos && state == ST_RUN && soft_min <= soft_max)
      |=> (pos_demand <= $past(soft_max)) && (pos_demand >= $past(soft_min)))
    else $error("position demand outside limits");
  chk_limit_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (following && mode_pos && over_lim) |=> status_word[STAT_LIMIT])
    else $error("limit flag missing");
  chk_lim_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (following && mode_pos && !over_lim && !under_lim) |=> !status_word[STAT_LIMIT])
    else $error("limit flag without a limit violation");
  chk_ferr_needs_out: assert property (@(posedge clk_sys) disable iff (rst)
    !outside |=> !ferr)
    else $error("following error while inside window");
  chk_ferr_on_tick: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(ferr) |-> $past(ms_tick))
    else $error("following error raised off the ms tick");
  chk_trq_offset: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> trq_demand == $past(trq_offset))
    else $error("torque offset not applied");
  cov_pos_follow: cover property (@(posedge clk_sys) disable iff (rst)
    mode_pos && following && boundary);
  cov_local_cycle: cover property (@(posedge clk_sys) disable iff (rst)
    !in_sync && following && boundary);
  cov_vel_follow: cover property (@(posedge clk_sys) disable iff (rst)
    mode_vel && following && boundary);
  cov_ferr: cover property (@(posedge clk_sys) disable iff (rst) $rose(ferr));
  cov_qstop: cover property (@(posedge clk_sys) disable iff (rst) state == ST_HALTED);
endmodule

// >>> tb/cyclic_master.sv
// Model of the higher-level controller that feeds setpoints and SYNC pulses
`timescale 1ns/1ps
module cyclic_master
  import csync_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             sp_ready,
  output logic [POS_W-1:0]      sp_data,
  output logic                  sp_valid,
  output logic                  sync_pulse,
  output logic                  stalled
);
  logic [POS_W-1:0] last_data;  // Last word offered

  // Idle state at time zero
  initial begin
    sp_data = '0;
    sp_valid = 1'b0;
    sync_pulse = 1'b0;
    last_data = '0;
    stalled = 1'b0;
  end

  // Wait a falling edge, offer one word, hold it until taken or 100 clocks pass, scramble the released data
  task automatic send(input logic [POS_W-1:0] value);
    int n;
    n = 0;
    @(negedge clk_sys);
    sp_data = value;
    sp_valid = 1'b1;
    last_data = value;
    do begin
      @(posedge clk_sys);
      n++;
    end while (sp_ready !== 1'b1 && n < 100);
    if (sp_ready !== 1'b1) begin
      stalled = 1'b1;
    end
    @(negedge clk_sys);
    sp_valid = 1'b0;
    sp_data = ~last_data;
  endtask

  // One-cycle SYNC pulse; setpoints are sent ahead of it each interval
  task automatic sync_tick();
    sync_pulse = 1'b1;
    @(negedge clk_sys);
    sync_pulse = 1'b0;
  endtask
endmodule

// >>> tb/cyclic_sync_setpoint_follower_tb_top.sv
// Self-checking bench for the cyclic synchronous setpoint follower
`timescale 1ns/1ps
module cyclic_sync_setpoint_follower_tb_top;
  import csync_pkg::*;
  logic              clk_sys = 1'b0;  // System clock
  logic              rst = 1'b1;      // Reset, high active
  logic [7:0]        op_mode = 8'h00;
  logic              operational = 1'b0;
  logic              sync_pulse, sp_valid, sp_ready, cycle_tick;
  logic              stalled;            // Model saw ready stay low
  logic              range_wrap = 1'b0;  // Range wrap enable
  logic              quick_stop = 1'b0;
  logic [1:0]        qs_option = QS_HOLD;
  logic [POS_W-1:0]  qs_decel = 32'h00000064;  // Braking step per clock
  logic [7:0]        interp_period = 8'h01;
  logic signed [7:0] interp_index = TIME_INDEX_MS;
  logic [POS_W-1:0]  sp_data, ferr_window = 32'h00000064;
  logic [15:0]       ferr_timeout_ms = 16'h03E8;
  logic signed [POS_W-1:0] actual_pos = '0, pos_offset = '0, vel_offset = '0;
  logic signed [POS_W-1:0] soft_min = -32'sd1000000, soft_max = 32'sd1000000;
  logic signed [POS_W-1:0] range_min = -32'sd2000000, range_max = 32'sd2000000;
  logic signed [TRQ_W-1:0] trq_offset = '0, trq_demand;
  logic signed [POS_W-1:0] pos_demand, vel_demand, val, off;
  logic [STAT_W-1:0] status_word;
  logic [31:0]       seed = 32'h0000003F;  // Random state
  logic [31:0]       r;
  int                bad_count = 0;
  int                comparisons = 0;
  int                ticks = 0;  // Cycle boundaries seen
  int                gap = 0;    // Clocks between two local boundaries

  // Clock of 50 ns period
  always #25 clk_sys = ~clk_sys;

  // Count cycle boundaries seen on the tick output
  always @(posedge clk_sys) begin
    if (cycle_tick === 1'b1) begin
      ticks++;
    end
  end

  cyclic_master cyclic_master_inst (.clk_sys(clk_sys), .sp_ready(sp_ready),
    .sp_data(sp_data), .sp_valid(sp_valid), .sync_pulse(sync_pulse), .stalled(stalled));

  cyclic_sync_setpoint_follower cyclic_sync_setpoint_follower_inst (
    .clk_sys(clk_sys), .rst(rst), .op_mode(op_mode), .operational(operational),
    .sync_pulse(sync_pulse), .quick_stop(quick_stop), .qs_option(qs_option),
    .qs_decel(qs_decel), .interp_period(interp_period), .interp_index(interp_index),
    .sp_data(sp_data), .sp_valid(sp_valid), .sp_ready(sp_ready),
    .actual_pos(actual_pos), .soft_min(soft_min), .soft_max(soft_max),
    .range_wrap(range_wrap), .range_min(range_min), .range_max(range_max),
    .ferr_window(ferr_window), .ferr_timeout_ms(ferr_timeout_ms),
    .pos_offset(pos_offset), .vel_offset(vel_offset), .trq_offset(trq_offset),
    .pos_demand(pos_demand), .vel_demand(vel_demand), .trq_demand(trq_demand),
    .status_word(status_word), .cycle_tick(cycle_tick));

  // Xorshift generator
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected commanded position inside the soft limits
  function automatic logic signed [31:0] clamp_pos(input logic signed [31:0] v);
    return (v > soft_max) ? soft_max : ((v < soft_min) ? soft_min : v);
  endfunction

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Send a setpoint some times, then close the cycle with a SYNC pulse
  task automatic run_cycle(input logic [31:0] value, input int copies);
    int t0;
    for (int i = 0; i < copies; i++) begin
      cyclic_master_inst.send(value);
    end
    repeat (3) @(negedge clk_sys);
    t0 = ticks;
    cyclic_master_inst.sync_tick();
    repeat (4) @(negedge clk_sys);
    check("cycle_tick", 32'(ticks - t0), 32'h1);
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (95000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    check("status_rst", 32'(status_word), 32'h0);
    check("ready_rst", 32'(sp_ready), 32'h1);
    op_mode = MODE_CSP;
    operational = 1'b1;
    cyclic_master_inst.sync_tick();
    repeat (2) @(negedge clk_sys);
    check("sync_on", 32'(status_word[STAT_SYNC]), 32'h1);
    // Random absolute targets, repeated, with offsets
    for (int k = 0; k < 6; k++) begin
      r = next_rand();
      val = {{13{r[18]}}, r[18:0]};
      off = {{25{r[31]}}, r[31:25]};
      pos_offset = off;
      trq_offset = r[15:0];
      run_cycle(val, 1 + int'(r[21]) + int'(r[22]));
      check("pos_demand", pos_demand, val + off);
      check("follow", 32'(status_word[STAT_FOLLOW]), 32'h1);
      check("limit_low", 32'(status_word[STAT_LIMIT]), 32'h0);
      check("trq_demand", {16'h0, trq_demand}, {16'h0, r[15:0]});
      actual_pos = val + off;
    end
    // Two different targets in one cycle, the later one counts
    pos_offset = '0;
    cyclic_master_inst.send(32'h00001234);
    run_cycle(32'h00005678, 1);
    check("last_wins", pos_demand, 32'h00005678);
    actual_pos = 32'sh00005678;
    // Target beyond the upper soft limit
    run_cycle(32'(soft_max + 32'sd5000), 1);
    check("clamped", pos_demand, clamp_pos(soft_max + 32'sd5000));
    check("limit_set", 32'(status_word[STAT_LIMIT]), 32'h1);
    // Overrun of a 1000-wide range wraps back by the range width
    range_wrap = 1'b1;
    range_min = '0;
    range_max = 32'sd999;
    run_cycle(32'sd1005, 1);
    check("wrapped", pos_demand, 32'sd1005 - 32'sd1000);
    range_wrap = 1'b0;
    run_cycle(32'h00001000, 1);
    // Actual position left outside the window for more than 1 ms
    actual_pos = 32'sh00001000 + 32'(ferr_window) + 32'sh10;
    ferr_timeout_ms = 16'h0001;
    repeat (5) @(negedge clk_sys);
    check("ferr_early", 32'(status_word[STAT_FERR]), 32'h0);
    for (int n = 0; n < 45000 && status_word[STAT_FERR] !== 1'b1; n++) begin
      @(negedge clk_sys);
    end
    check("ferr_set", 32'(status_word[STAT_FERR]), 32'h1);
    actual_pos = 32'sh00001000;
    ferr_timeout_ms = 16'h03E8;
    // Unsupported time index drops target following
    interp_index = -8'sd2;
    repeat (3) @(negedge clk_sys);
    check("bad_index", 32'(status_word[STAT_FOLLOW]), 32'h0);
    interp_index = TIME_INDEX_MS;
    // Velocity mode
    op_mode = MODE_CSV;
    r = next_rand();
    vel_offset = {26'h0, r[5:0]};
    cyclic_master_inst.sync_tick();
    run_cycle(32'h000001F4, 1);
    check("vel_demand", vel_demand, 32'sh1F4 + vel_offset);
    check("vel_follow", 32'(status_word[STAT_FOLLOW]), 32'h1);
    check("vel_resv", 32'(status_word & 16'h2400), 32'h0);
    check("vel_sync", 32'(status_word[STAT_SYNC]), 32'h1);
    // Quick stop brakes velocity down to zero
    quick_stop = 1'b1;
    repeat (40) @(negedge clk_sys);
    check("qs_stop", vel_demand, 32'h0);
    quick_stop = 1'b0;
    // Leaving the Operational state loses sync
    operational = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("sync_off", 32'(status_word[STAT_SYNC]), 32'h0);
    // Without sync the cycle comes from the local ms count
    cyclic_master_inst.send(32'h00000300);
    for (int n = 0; n < 25000 && cycle_tick !== 1'b1; n++) begin
      @(negedge clk_sys);
    end
    gap = 0;
    do begin
      @(negedge clk_sys);
      gap++;
    end while (cycle_tick !== 1'b1 && gap < 25000);
    check("local_period", 32'(gap), 32'(MS_CYCLES) * 32'(interp_period));
    repeat (3) @(negedge clk_sys);
    check("local_cycle", vel_demand, 32'sh300 + vel_offset);
    // Leaving the cyclic modes stops target following
    op_mode = 8'h00;
    repeat (2) @(negedge clk_sys);
    check("mode_off", 32'(status_word[STAT_FOLLOW]), 32'h0);
    check("no_stall", 32'(stalled), 32'h0);
    complete_run();
  end
endmodule
